//--- verification/card_model.sv
// card side of both sockets: card clock and the two error pins
`timescale 1ns/1ps
module card_model (
    output logic [1:0] cclk,
    output logic [1:0] cperr_n,
    output logic [1:0] cserr_n
);
    initial
    begin
        cclk = 2'h0;
        cperr_n = 2'h3;
        cserr_n = 2'h3;
    end
    // four card clocks per frame; the clock is parked low between frames
    task automatic frame(input int s, input bit serr, input bit perr);
        cserr_n[s] = !serr;
        cperr_n[s] = !perr;
        repeat (4)
        begin
            #16 cclk[s] = 1'h1;
            #16 cclk[s] = 1'h0;
        end
        // pull-ups take the pins high once the card lets go
        cserr_n[s] = 1'h1;
        cperr_n[s] = 1'h1;
    endtask
endmodule // card_model

//--- verification/cb_status_checker.sv
// assertions on the socket status and bus number register block
`timescale 1ns/1ps
module cb_status_checker #(
    parameter NFUNC  = 2,
    parameter FUNC_W = 1
) (
    input wire               mclk,
    input wire               rst,
    input wire               cfg_rd,
    input wire               cfg_wr,
    input wire [FUNC_W-1:0]  cfg_func,
    input wire [5:0]         cfg_addr,
    input wire [3:0]         cfg_be,
    input wire [31:0]        cfg_wdata,
    input wire [31:0]        cfg_rdata,
    input wire               cfg_ack,
    input wire               fwd_req,
    input wire [7:0]         fwd_bus,
    input wire [NFUNC-1:0]   fwd_type0,
    input wire [NFUNC-1:0]   fwd_type1,
    input wire [NFUNC-1:0]   fwd_local,
    input wire               fwd_valid,
    input wire [8*NFUNC-1:0] primary_bus_number,
    input wire [8*NFUNC-1:0] secondary_bus_number,
    input wire [8*NFUNC-1:0] subordinate_bus_number
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    a_ack_after_req: assert property ((cfg_rd || cfg_wr) |=> cfg_ack)
        else $error("config ack missing");
    a_no_stray_ack: assert property (!(cfg_rd || cfg_wr) |=> !cfg_ack)
        else $error("config ack without request");
    a_fixed_status_bits: assert property (
        cfg_ack && $past(cfg_rd) && $past(cfg_addr) == 6'h05
        |-> cfg_rdata[26:25] == 2'h1 && cfg_rdata[23:0] == 24'h0)
        else $error("fixed status bits wrong");
    a_busnum_top_zero: assert property (
        cfg_ack && $past(cfg_rd) && $past(cfg_addr) == 6'h06
        |-> cfg_rdata[31:24] == 8'h00)
        else $error("bus number top byte not zero");
    a_cardbus_num_written: assert property (
        cfg_wr && cfg_func == 0 && cfg_addr == 6'h06 && cfg_be[1]
        |=> secondary_bus_number[7:0] == $past(cfg_wdata[15:8]))
        else $error("secondary_bus_number not written");
    a_type0_match: assert property (
        fwd_req |=> fwd_type0[0] == ($past(fwd_bus)
        == $past(secondary_bus_number[7:0]) && $past(fwd_bus)
        != $past(primary_bus_number[7:0])))
        else $error("type 0 decision wrong");
    a_type1_range: assert property (
        fwd_req |=> fwd_type1[1] == ($past(fwd_bus)
        > $past(secondary_bus_number[15:8]) && $past(fwd_bus)
        <= $past(subordinate_bus_number[15:8]) && $past(fwd_bus)
        != $past(primary_bus_number[15:8])))
        else $error("type 1 decision wrong");
    a_fwd_valid_pulse: assert property (fwd_req |=> fwd_valid)
        else $error("forward valid missing");
    a_fwd_held: assert property (!fwd_req |=> !fwd_valid
        && $stable({fwd_type0, fwd_type1, fwd_local}))
        else $error("forward decision changed unasked");
endmodule // cb_status_checker

bind cardbus_secondary_status_busnum cb_status_checker #(
    .NFUNC(NFUNC), .FUNC_W(FUNC_W)) chk (.mclk, .rst, .cfg_rd, .cfg_wr,
    .cfg_func, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack,
    .fwd_req, .fwd_bus, .fwd_type0, .fwd_type1, .fwd_local, .fwd_valid,
    .primary_bus_number, .secondary_bus_number, .subordinate_bus_number);

//--- verification/tb_top.sv
// self-checking bench for the socket status and bus number registers
`timescale 1ns/1ps
module tb_top;
    logic mclk = 1'h0, rst = 1'h1, global_reset_input = 1'h1;
    logic cfg_rd = 1'h0, cfg_wr = 1'h0, fwd_req = 1'h0;
    logic [0:0] cfg_func = 1'h0;
    logic [5:0] cfg_addr = 6'h00;
    logic [3:0] cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0, cfg_rdata, rv;
    logic cfg_ack, fwd_valid;
    logic [7:0] fwd_bus = 8'h00;
    logic [1:0] cclk, cperr_n, cserr_n, fwd_type0, fwd_type1, fwd_local;
    logic [1:0] evt [4] = '{default: 2'h0};
    logic [1:0] master_data_phase = 2'h0, parity_resp_en = 2'h0;
    logic [15:0] primary_bus_number, secondary_bus_number;
    logic [15:0] subordinate_bus_number;
    logic [7:0] bl [8] = '{8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
                           8'h09, 8'h0A};
    int bp [4] = '{15, 13, 12, 11};
    int miscompares = 0, check_count = 0;

    cardbus_secondary_status_busnum uut (
        .mclk, .rst, .global_reset_input, .cfg_rd, .cfg_wr, .cfg_func,
        .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack, .cclk,
        .cperr_n, .cserr_n, .parity_err_evt(evt[0]),
        .master_abort_evt(evt[1]), .target_abort_rcvd_evt(evt[2]),
        .target_abort_sig_evt(evt[3]), .master_data_phase,
        .parity_resp_en, .fwd_req, .fwd_bus, .fwd_type0, .fwd_type1,
        .fwd_local, .fwd_valid, .primary_bus_number,
        .secondary_bus_number, .subordinate_bus_number);
    card_model card (.cclk, .cperr_n, .cserr_n);

    always #2 mclk = ~mclk;

    task automatic chk(input string n, input logic [31:0] e, s);
        check_count++;
        if (s !== e)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic hold(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // one access plus an idle cycle so strobes are never reassigned at once
    task automatic cyc(input logic w, f, input logic [5:0] a,
                       input logic [3:0] b, input logic [31:0] d);
        cfg_wr = w;
        cfg_rd = !w;
        cfg_func = f;
        cfg_addr = a;
        cfg_be = b;
        cfg_wdata = d;
        hold(1);
        cfg_wr = 1'h0;
        cfg_rd = 1'h0;
        chk("cfg_ack", 32'h1, {31'h0, cfg_ack});
        rv = cfg_rdata;
        hold(1);
    endtask
    task automatic rdc(input logic f, input logic [5:0] a,
                       input logic [31:0] e, input string n);
        cyc(1'h0, f, a, 4'h0, 32'h0);
        chk(n, e, rv);
    endtask
    function automatic logic [31:0] fexp(input logic [7:0] b);
        logic [1:0] l, z, o;
        l = {2{b == 8'h01}};
        z = {b == 8'h07, b == 8'h03} & ~l;
        o = {b > 8'h07 && b <= 8'h09, b > 8'h03 && b <= 8'h05} & ~l;
        return {26'h0, l, z, o};
    endfunction

    task automatic t_reset;
        rdc(0, 6'h05, 32'h0200_0000, "status0");
        rdc(1, 6'h05, 32'h0200_0000, "status1");
        rdc(0, 6'h06, 32'h0, "busnums");
        rdc(0, 6'h07, 32'h0, "unmapped");
    endtask
    task automatic t_fwd;
        cyc(1, 0, 6'h06, 4'hF, 32'hFF05_0301);
        cyc(1, 1, 6'h06, 4'h7, 32'h0009_0701);
        rdc(0, 6'h06, 32'h0005_0301, "busnums0");
        rdc(1, 6'h06, 32'h0009_0701, "busnums1");
        for (int i = 0; i < 8; i++)
        begin
            fwd_bus = bl[i];
            fwd_req = 1'h1;
            hold(1);
            fwd_req = 1'h0;
            rv = {26'h0, fwd_local, fwd_type0, fwd_type1};
            chk("fwd", fexp(bl[i]), rv);
            chk("fwd_valid", 32'h1, {31'h0, fwd_valid});
            hold(1);
        end
    endtask
    task automatic t_events;
        logic [31:0] m;
        for (int k = 0; k < 4; k++)
        begin
            m = 32'h0200_0000 | (32'h1 << (16 + bp[k]));
            evt[k] = 2'h1;
            hold(1);
            evt[k] = 2'h0;
            rdc(0, 6'h05, m, "set");
            rdc(1, 6'h05, 32'h0200_0000, "other");
            cyc(1, 0, 6'h05, 4'h4, 32'hFFFF_FFFF);
            cyc(1, 0, 6'h05, 4'h8, 32'h0);
            rdc(0, 6'h05, m, "kept");
            cyc(1, 0, 6'h05, 4'hF, 32'hFFFF_FFFF);
            rdc(0, 6'h05, 32'h0200_0000, "cleared");
        end
    endtask
    task automatic t_collide;
        // event and write-one clear meet at one edge, nowhere else
        evt[1] = 2'h1;
        cfg_wr = 1'h1;
        cfg_func = 1'h0;
        cfg_addr = 6'h05;
        cfg_be = 4'h8;
        cfg_wdata = 32'h2000_0000;
        hold(1);
        evt[1] = 2'h0;
        cfg_wr = 1'h0;
        chk("collide_ack", 32'h1, {31'h0, cfg_ack});
        hold(1);
        rdc(0, 6'h05, 32'h2200_0000, "collide");
        cyc(1, 0, 6'h05, 4'h8, 32'h2000_0000);
    endtask
    task automatic t_pins;
        master_data_phase = 2'h3;
        card.frame(1, 1'h1, 1'h0);
        rdc(1, 6'h05, 32'h4200_0000, "serr1");
        rdc(0, 6'h05, 32'h0200_0000, "serr0");
        card.frame(0, 1'h0, 1'h1);
        cyc(0, 0, 6'h05, 4'h0, 32'h0);
        chk("dpar_off", 32'h0, {31'h0, rv[24]});
        parity_resp_en = 2'h1;
        card.frame(0, 1'h0, 1'h1);
        cyc(0, 0, 6'h05, 4'h0, 32'h0);
        chk("dpar_on", 32'h1, {31'h0, rv[24]});
        master_data_phase = 2'h0;
        parity_resp_en = 2'h0;
    endtask
    task automatic t_sticky;
        rst = 1'h1;
        hold(3);
        rst = 1'h0;
        hold(3);
        rdc(1, 6'h05, 32'h4200_0000, "after_rst");
        global_reset_input = 1'h1;
        hold(3);
        global_reset_input = 1'h0;
        hold(3);
        rdc(1, 6'h05, 32'h0200_0000, "after_grst1");
        rdc(0, 6'h05, 32'h0200_0000, "after_grst0");
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        hold(20);
        // the global reset needs its sync flops out of reset to land
        rst = 1'h0;
        hold(4);
        global_reset_input = 1'h0;
        hold(3);
        t_reset;
        t_fwd;
        t_events;
        t_collide;
        t_pins;
        t_sticky;
        tally_and_finish;
    end
    // the tests need a few hundred cycles; this is far beyond that
    initial
    begin
        #100000;
        miscompares++;
        tally_and_finish;
    end
endmodule // tb_top

//--- verilog/cardbus_secondary_status_busnum.v
// per-socket secondary status and bus number registers of a cardbus bridge
//
// Overview of operation
// R1 - set status bit 15 on any cardbus address or data parity error
// R2 - set status bit 14 when the card asserts its system error line
// R3 - the system error line is an input only, never driven here
// R4 - set status bit 13 when our own cardbus cycle ends in master abort
// R5 - set status bit 12 when the target aborts our own cardbus cycle
// R6 - set status bit 11 when we as target abort a cardbus cycle
// R7 - bits 10 to 9 read fixed 01b, medium select timing; writes ignored
// R8 - set bit 8 on perr in our master data phase with response enabled
// R9 - bit 7 reads 0, no fast back-to-back acceptance
// R10 - bit 6 reads 0, no user-definable features
// R11 - bit 5 reads 0, card clock is at most 33 MHz
// R12 - bits 4 to 0 are reserved and read zero
// R13 - writing 1 clears an error bit; writing 0 leaves it alone
// R14 - sticky error bits clear only on the global reset input
// R15 - each socket function has its own status word
// R16 - primary bus number, 8-bit read/write, resets to 00h
// R17 - secondary_bus_number, 8-bit read/write, resets to 00h
// R18 - forwarding decision uses primary, cardbus and subordinate numbers
// R19 - each function keeps its own secondary_bus_number
// R20 - subordinate bus number, 8-bit read/write, highest bus below cardbus
// R21 - claim own cardbus number as type 0, higher up to subordinate type 1
// R22 - a set and a write-one clear in the same clock leave the bit set
`timescale 1ns/1ps
`include "cb_status_regs.vh"

module cardbus_secondary_status_busnum #(
    parameter NFUNC  = 2,
    parameter FUNC_W = 1
) (
    input  wire                mclk,
    input  wire                rst,
    input  wire                global_reset_input,
    // configuration access port
    input  wire                cfg_rd,
    input  wire                cfg_wr,
    input  wire [FUNC_W-1:0]   cfg_func,
    input  wire [5:0]          cfg_addr,
    input  wire [3:0]          cfg_be,
    input  wire [31:0]         cfg_wdata,
    output reg  [31:0]         cfg_rdata,
    output reg                 cfg_ack,
    // card pins, one per socket
    input  wire [NFUNC-1:0]    cclk,
    input  wire [NFUNC-1:0]    cperr_n,
    input  wire [NFUNC-1:0]    cserr_n,
    // events from the cardbus transaction logic, one-cycle pulses, then two level qualifiers
    input  wire [NFUNC-1:0]    parity_err_evt,
    input  wire [NFUNC-1:0]    master_abort_evt,
    input  wire [NFUNC-1:0]    target_abort_rcvd_evt,
    input  wire [NFUNC-1:0]    target_abort_sig_evt,
    input  wire [NFUNC-1:0]    master_data_phase,
    input  wire [NFUNC-1:0]    parity_resp_en,
    // configuration forwarding decision
    input  wire                fwd_req,
    input  wire [7:0]          fwd_bus,
    output reg  [NFUNC-1:0]    fwd_type0,
    output reg  [NFUNC-1:0]    fwd_type1,
    output reg  [NFUNC-1:0]    fwd_local,
    output reg                 fwd_valid,
    // the bus numbers, for the rest of the bridge
    output wire [8*NFUNC-1:0]  primary_bus_number,
    output wire [8*NFUNC-1:0]  secondary_bus_number,
    output wire [8*NFUNC-1:0]  subordinate_bus_number
);

    // synchronised pins: card clocks, perr, serr, then the global reset
    wire [3*NFUNC:0] pins_raw;
    wire [3*NFUNC:0] pins_s;
    wire             global_reset_input_s;

    // all status words side by side for the read path
    wire [16*NFUNC-1:0] status_all;

    assign pins_raw = {global_reset_input, cserr_n, cperr_n, cclk};

    // error pins idle high and card clocks low so a sync reset does not fake an error
    sync2 #(
        .WIDTH (3*NFUNC+1),
        .INIT  ({1'b0, {(2*NFUNC){1'b1}}, {NFUNC{1'b0}}})
    ) u_pin_sync (
        .mclk  (mclk),
        .rst   (rst),
        .din   (pins_raw),
        .dout  (pins_s)
    );

    assign global_reset_input_s = pins_s[3*NFUNC];

    // common decode of the config port
    wire wr_status;
    wire wr_busnum;

    assign wr_status = cfg_wr && (cfg_addr == `CB_DW_STATUS);
    assign wr_busnum = cfg_wr && (cfg_addr == `CB_DW_BUSNUM);

    genvar f;
    generate
        for (f = 0; f < NFUNC; f = f + 1)
        begin : g_func
            localparam [FUNC_W-1:0] FN = f;

            wire        cclk_s;
            wire        cperr_n_s;
            wire        cserr_n_s;
            wire        cclk_rise;
            wire        sel;
            wire [15:0] clr_mask;
            wire [15:0] set_mask;
            wire [15:0] status_nxt;
            wire [15:0] status_word;
            wire        above_sec;
            wire        upto_sub;

            reg         cclk_prev_r;
            reg  [15:0] status_r;
            reg  [7:0]  pri_bus_r;
            reg  [7:0]  sec_bus_r;
            reg  [7:0]  sub_bus_r;

            assign cclk_s    = pins_s[f];
            assign cperr_n_s = pins_s[NFUNC+f];
            assign cserr_n_s = pins_s[2*NFUNC+f];

            // card pins are sampled on the synchronised rising card clock;
            // all three pass the same two flops so they stay aligned
            always @(posedge mclk)
            begin
                if (rst)
                    cclk_prev_r <= 1'b0;
                else
                    cclk_prev_r <= cclk_s;
            end

            assign cclk_rise = cclk_s & ~cclk_prev_r;

            assign sel = (cfg_func == FN);

            // write-one clears, upper byte of the dword only holds them
            assign clr_mask = (wr_status && sel && cfg_be[3]) ?
                              (cfg_wdata[31:16] & `CB_STICKY_MASK) :
                              16'h0000;                             // [R13]

            assign set_mask[`CB_BIT_PARITY]  = parity_err_evt[f];   // [R1]
            // serr is only watched here, no drive path exists
            assign set_mask[`CB_BIT_SERR]    = cclk_rise &
                                               ~cserr_n_s;  // [R2] [R3]
            assign set_mask[`CB_BIT_MABORT]  = master_abort_evt[f]; // [R4]
            assign set_mask[`CB_BIT_TA_RCVD] =
                target_abort_rcvd_evt[f];                           // [R5]
            assign set_mask[`CB_BIT_TA_SIG]  =
                target_abort_sig_evt[f];                            // [R6]
            assign set_mask[`CB_BIT_DPAR]    = cclk_rise & ~cperr_n_s &
                                               master_data_phase[f] &
                                               parity_resp_en[f];   // [R8]
            assign set_mask[10:9] = 2'h0;
            assign set_mask[7:0]  = 8'h00;

            // the set term is or-ed in last so it beats a same-cycle clear
            assign status_nxt = ((status_r & ~clr_mask) | set_mask) &
                                `CB_STICKY_MASK;                    // [R22]

            // only the global reset touches the sticky bits
            always @(posedge mclk)
            begin
                if (global_reset_input_s)
                    status_r <= `CB_STATUS_RESET;                   // [R14]
                else
                    status_r <= status_nxt;                         // [R15]
            end

            // the fixed fields are built on read, nothing stores them
            assign status_word[15:11] = status_r[15:11];
            assign status_word[10:9]  = `CB_TIMING_CODE;            // [R7]
            assign status_word[8]     = status_r[8];
            assign status_word[`CB_BIT_B2B]   = 1'b0;               // [R9]
            assign status_word[`CB_BIT_UDF]   = 1'b0;               // [R10]
            assign status_word[`CB_BIT_66MHZ] = 1'b0;               // [R11]
            assign status_word[4:0]   = 5'h00;                      // [R12]

            assign status_all[16*f +: 16] = status_word;

            // bus numbers: byte lanes 0, 1, 2 of the dword at 18h
            always @(posedge mclk)
            begin
                if (rst || global_reset_input_s)
                begin
                    pri_bus_r <= `CB_BUS_RESET;                     // [R16]
                    sec_bus_r <= `CB_BUS_RESET;                     // [R17]
                    sub_bus_r <= `CB_BUS_RESET;
                end
                else if (wr_busnum && sel)
                begin
                    if (cfg_be[0])
                        pri_bus_r <= cfg_wdata[7:0];                // [R16]
                    if (cfg_be[1])
                        sec_bus_r <= cfg_wdata[15:8];        // [R17] [R19]
                    if (cfg_be[2])
                        sub_bus_r <= cfg_wdata[23:16];              // [R20]
                end
            end

            assign primary_bus_number[8*f +: 8]     = pri_bus_r;
            assign secondary_bus_number[8*f +: 8]   = sec_bus_r;
            assign subordinate_bus_number[8*f +: 8] = sub_bus_r;

            // type 1 window is strictly above the cardbus number
            assign above_sec = (fwd_bus > sec_bus_r);
            assign upto_sub  = (fwd_bus <= sub_bus_r);

            // a bad subordinate setting simply yields no type 1 window
            always @(posedge mclk)
            begin
                if (rst)
                begin
                    fwd_type0[f] <= 1'b0;
                    fwd_type1[f] <= 1'b0;
                    fwd_local[f] <= 1'b0;
                end
                else if (fwd_req)
                begin
                    fwd_local[f] <= (fwd_bus == pri_bus_r);         // [R18]
                    fwd_type0[f] <= (fwd_bus != pri_bus_r) &&
                                    (fwd_bus == sec_bus_r);  // [R18] [R21]
                    fwd_type1[f] <= (fwd_bus != pri_bus_r) &&
                                    above_sec && upto_sub;   // [R18] [R21]
                end
            end
        end
    endgenerate

    always @(posedge mclk)
    begin
        if (rst)
            fwd_valid <= 1'b0;
        else
            fwd_valid <= fwd_req;
    end

    // read path: one register stage, unmapped dwords read zero
    always @(posedge mclk)
    begin
        if (rst)
        begin
            cfg_rdata <= 32'h00000000;
            cfg_ack   <= 1'b0;
        end
        else
        begin
            cfg_ack <= cfg_rd | cfg_wr;
            if (cfg_rd)
            begin
                case (cfg_addr)
                    `CB_DW_STATUS:
                        cfg_rdata <= {status_all[{cfg_func, 4'h0} +: 16],
                                      16'h0000};                    // [R15]
                    `CB_DW_BUSNUM:
                        cfg_rdata <= {8'h00,
                                      subordinate_bus_number[
                                          {cfg_func, 3'h0} +: 8],
                                      secondary_bus_number[
                                          {cfg_func, 3'h0} +: 8],
                                      primary_bus_number[
                                          {cfg_func, 3'h0} +: 8]};
                    default:
                        cfg_rdata <= 32'h00000000;
                endcase
            end
            else
            begin
                cfg_rdata <= 32'h00000000;
            end
        end
    end

endmodule // cardbus_secondary_status_busnum

//--- verilog/cb_status_regs.vh
// offsets, field positions and reset values of the socket config registers
`ifndef CB_STATUS_REGS_VH
`define CB_STATUS_REGS_VH

// byte offsets in each function's configuration space
`define CB_OFS_SEC_STATUS      8'h16
`define CB_OFS_PRI_BUS         8'h18
`define CB_OFS_SEC_BUS         8'h19
`define CB_OFS_SUB_BUS         8'h1A

// dword indices (byte offset / 4) seen on the config port
`define CB_DW_STATUS           6'h05
`define CB_DW_BUSNUM           6'h06

// secondary status bit positions
`define CB_BIT_PARITY          15
`define CB_BIT_SERR            14
`define CB_BIT_MABORT          13
`define CB_BIT_TA_RCVD         12
`define CB_BIT_TA_SIG          11
`define CB_BIT_TIMING_HI       10
`define CB_BIT_TIMING_LO       9
`define CB_BIT_DPAR            8
`define CB_BIT_B2B             7
`define CB_BIT_UDF             6
`define CB_BIT_66MHZ           5

// sticky write-one-to-clear bits, fixed timing field and constant bits
`define CB_STICKY_MASK         16'hF900
`define CB_TIMING_CODE         2'h1
`define CB_STATUS_RESET        16'h0000
`define CB_FIXED_ZERO_BITS     16'h00FF

// bus number reset value
`define CB_BUS_RESET           8'h00

`endif

//--- verilog/sync2.v
// two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps

module sync2 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
    input  wire             mclk,
    input  wire             rst,
    input  wire [WIDTH-1:0] din,
    output wire [WIDTH-1:0] dout
);

    reg [WIDTH-1:0] meta_r;
    reg [WIDTH-1:0] sync_r;

    always @(posedge mclk)
    begin
        if (rst)
        begin
            meta_r <= INIT;
            sync_r <= INIT;
        end
        else
        begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;

endmodule // sync2
